/* core/rss_pkg.sv */
/*
 Constants for the robot sensor sequencer: timing, register offsets,
 command codes, selector codes and accelerometer register map.
 Assumes a 25 MHz core clock.
*/
package rss_pkg;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int          CLK_MHZ        = 25;
   localparam int          LINE_WAIT_US   = 900;
   localparam logic [15:0] LINE_WAIT_CYC  = 16'(LINE_WAIT_US * CLK_MHZ);
   localparam int          IR_PULSE_US    = 10;
   localparam logic [15:0] IR_PULSE_CYC   = 16'(IR_PULSE_US * CLK_MHZ);
   localparam int          IR_SETTLE_US   = 10;
   localparam logic [15:0] IR_SETTLE_CYC  = 16'(IR_SETTLE_US * CLK_MHZ);
   localparam int          BLINK_HALF_MS  = 500;
   localparam logic [23:0] BLINK_HALF_CYC = 24'(BLINK_HALF_MS * CLK_MHZ * 1000);
   localparam logic [7:0]  SPI_HALF_CYC   = 8'h04;
   // ***************************************************
   // Register bus
   // ***************************************************
   localparam int         ADDR_W      = 4;
   localparam int         DATA_W      = 8;
   localparam logic [3:0] REG_COMMAND = 4'h0;
   localparam logic [3:0] REG_OBS_SEL = 4'h1;
   localparam logic [3:0] REG_AXIS_SEL = 4'h2;
   localparam logic [3:0] REG_LINE_SEL = 4'h3;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_OBS_RES = 4'h5;
   localparam logic [3:0] REG_ACC_RES = 4'h6;
   localparam logic [3:0] REG_TAP     = 4'h7;
   localparam logic [3:0] REG_LINE_RES = 4'h8;
   localparam logic [3:0] REG_LED_CMD = 4'h9;
   localparam logic [3:0] REG_LED_STATE = 4'hA;
   localparam int ST_OK_BIT   = 0;
   localparam int ST_BAD_BIT  = 1;
   localparam int ST_BUSY_BIT = 2;
   // ***************************************************
   // Commands and selector codes
   // ***************************************************
   localparam logic [2:0] OP_OBS_DIG  = 3'h1;
   localparam logic [2:0] OP_OBS_ANA  = 3'h2;
   localparam logic [2:0] OP_AXIS     = 3'h3;
   localparam logic [2:0] OP_TAP      = 3'h4;
   localparam logic [2:0] OP_LINE_DIG = 3'h5;
   localparam logic [2:0] OP_LINE_ANA = 3'h6;
   localparam logic [7:0] center_left_code  = 8'h00;
   localparam logic [7:0] side_left_code    = 8'h01;
   localparam logic [7:0] center_right_code = 8'h02;
   localparam logic [7:0] side_right_code   = 8'h03;
   localparam logic [7:0] x_axis_code = 8'h00;
   localparam logic [7:0] y_axis_code = 8'h01;
   localparam logic [7:0] z_axis_code = 8'h02;
   localparam logic [7:0] line_left_code  = 8'h00;
   localparam logic [7:0] line_right_code = 8'h01;
   localparam logic [1:0] LED_ON    = 2'h1;
   localparam logic [1:0] LED_OFF   = 2'h2;
   localparam logic [1:0] LED_BLINK = 2'h3;
   localparam int         LAMPS     = 4;
   localparam logic [2:0] ADC_LINE_BASE = 3'h4;
   // ***************************************************
   // Accelerometer map
   // ***************************************************
   localparam logic [5:0] ACC_MODE_REG  = 6'h16;
   localparam logic [5:0] ACC_STAT_REG  = 6'h09;
   localparam logic [5:0] ACC_X_REG     = 6'h06;
   localparam logic [5:0] ACC_TAP_REG   = 6'h0B;
   localparam logic [7:0] ACC_MEASURE   = 8'h05;
   localparam logic [7:0] ACC_TAP_MODE  = 8'h07;
   localparam int         ACC_DRDY_BIT  = 0;
   localparam int         ACC_SINGLE_BIT = 0;
   localparam int         ACC_DOUBLE_BIT = 1;
   localparam int         TAP_SINGLE_BIT = 0;
   localparam int         TAP_DOUBLE_BIT = 1;
   localparam logic [4:0] SPI_LAST_BIT  = 5'h0F;
endpackage : rss_pkg

/* core/rss_spi_if.sv */
/*
 Request and answer bundle between sequencer and SPI engine.
 Assumes both ends on core_clk.
*/
`timescale 1ns/1ns
interface rss_spi_if;
   logic       start;
   logic       write;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       busy;
   logic       done;
   modport master (output start, write, addr, wdata, input rdata, busy, done);
   modport engine (input start, write, addr, wdata, output rdata, busy, done);
endinterface : rss_spi_if

/* core/rss_spi.sv */
/*
 SPI mode 0 engine: one 16-bit frame, command byte then data byte.
 Assumes miso already synchronised by the caller.
*/
`timescale 1ns/1ns
module rss_spi
   import rss_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Request
   rss_spi_if.engine bus,
   // Pins
   output logic      spi_sclk,
   output logic      spi_mosi,
   output logic      spi_cs_n,
   input  wire logic miso_s
);
   logic [15:0] shift;
   logic [7:0]  rx;
   logic [4:0]  bitcnt;
   logic [7:0]  divcnt;
   logic        active;

   assign bus.busy = active;
   assign spi_mosi = shift[15];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift     <= 16'h0000;
         rx        <= 8'h00;
         bitcnt    <= 5'h00;
         divcnt    <= 8'h00;
         active    <= 1'b0;
         spi_sclk  <= 1'b0;
         spi_cs_n  <= 1'b1;
         bus.done  <= 1'b0;
         bus.rdata <= 8'h00;
      end else begin
         bus.done <= 1'b0;
         if (!active) begin
            if (bus.start) begin
               shift    <= {bus.write, 1'b0, bus.addr, bus.wdata};
               bitcnt   <= 5'h00;
               divcnt   <= 8'h00;
               active   <= 1'b1;
               spi_cs_n <= 1'b0;
            end
         end else if (divcnt == SPI_HALF_CYC - 8'h01) begin
            divcnt <= 8'h00;
            if (!spi_sclk) begin
               spi_sclk <= 1'b1;
               rx       <= {rx[6:0], miso_s};
            end else begin
               spi_sclk <= 1'b0;
               shift    <= {shift[14:0], 1'b0};
               bitcnt   <= bitcnt + 5'h01;
               if (bitcnt == SPI_LAST_BIT) begin
                  active    <= 1'b0;
                  spi_cs_n  <= 1'b1;
                  bus.done  <= 1'b1;
                  bus.rdata <= rx;
               end
            end
         end else begin
            divcnt <= divcnt + 8'h01;
         end
      end
   end
endmodule : rss_spi

/* core/rss_top.sv */
/*
 Robot sensor sequencer: obstacle, line and accelerometer reads and
 four indicator lamps, driven from a small register port.
 Assumes external IR receivers (high = IR seen), an ADC with
 start/done handshake and an SPI accelerometer.
*/
// Our own choices: the register addresses and the address-and-strobe port.
// Contract
// R1: A digital obstacle read checks for interference, fires the emitter, stores the level, turns it off.
// R2: After the emitter is off the receivers are checked again and read ok is set only if all was clean.
// R3: Obstacle selector codes are 0 centre left, 1 side left, 2 centre right, 3 side right.
// R4: An analog obstacle read converts the selected receiver after the pulse, larger meaning nearer.
// R5: The acceleration result is an offset 8-bit code where 0 is -2 G and 255 is +2 G.
// R6: An axis read sets measure mode, waits for data, reads the axis and restores tap mode.
// R7: Axis selector codes are 0 for X, 1 for Y and 2 for Z.
// R8: A tap check reads the tap state and sets bit 1 for double tap and bit 0 for single tap.
// R9: A digital line read fires the line emitter, waits 900 us and stores 1 for a dark surface.
// R10: An analog line read fires the line emitter, waits 900 us and stores larger values for darker.
// R11: Line selector codes are 0 left and 1 right.
// R12: Each of the four lamps takes on, off and blink commands.
// R13: Blinking toggles the lamp at a fixed period until an on or off command arrives.
// R14: An out of range selector sets bad data, clears read ok and touches no sensor.
`timescale 1ns/1ns
module rss_top
   import rss_pkg::*;
#(
   parameter logic [15:0] LINE_WAIT     = rss_pkg::LINE_WAIT_CYC,
   parameter logic [23:0] BLINK_HALF    = rss_pkg::BLINK_HALF_CYC
)(
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   // Register port
   input  wire logic [rss_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [rss_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [rss_pkg::DATA_W-1:0]  reg_rdata,
   // Obstacle IR
   input  wire logic [3:0]                  ir_rx,
   output logic                             ir_emit,
   // Line IR
   input  wire logic [1:0]                  line_rx,
   output logic                             line_emit,
   // ADC
   output logic                             adc_start,
   output logic      [2:0]                  adc_chan,
   input  wire logic                        adc_done,
   input  wire logic [7:0]                  adc_data,
   // Accelerometer SPI
   output logic                             spi_sclk,
   output logic                             spi_mosi,
   output logic                             spi_cs_n,
   input  wire logic                        spi_miso,
   // Lamps: brake, front, top red, top green
   output logic      [rss_pkg::LAMPS-1:0]   lamp
);
   import rss_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_PRE, S_FIRE, S_ADC, S_OFF, S_POST,
      S_LFIRE, S_A_MODE, S_A_POLL, S_A_READ, S_A_BACK, S_T_READ
   } rss_state_type;

   rss_state_type state;
   logic [2:0]    op;
   logic [7:0]    cur_sel;
   logic [15:0]   tmr;
   logic          issued;
   logic [7:0]    obs_sel;
   logic [7:0]    axis_sel;
   logic [7:0]    line_sel;
   logic          read_ok_flag;
   logic          bad_data_flag;
   logic [7:0]    obstacle_result;
   logic [7:0]    acceleration_value;
   logic [7:0]    tap_event_flags;
   logic [7:0]    line_result;
   logic [1:0]    lamp_mode [LAMPS];
   logic [23:0]   blink_cnt;
   logic          blink_phase;
   logic [3:0]    ir_m;
   logic [3:0]    ir_s;
   logic [1:0]    line_m;
   logic [1:0]    line_s;
   logic          done_m;
   logic          done_s;
   logic          done_q;
   logic [7:0]    data_m;
   logic [7:0]    data_s;
   logic          miso_m;
   logic          miso_s;
   logic          cmd_wr;
   logic          sel_bad;
   logic          adc_edge;

   rss_spi_if spi ();

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_m   <= 4'h0;
         ir_s   <= 4'h0;
         line_m <= 2'h0;
         line_s <= 2'h0;
         done_m <= 1'b0;
         done_s <= 1'b0;
         done_q <= 1'b0;
         data_m <= 8'h00;
         data_s <= 8'h00;
         miso_m <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         ir_m   <= ir_rx;
         ir_s   <= ir_m;
         line_m <= line_rx;
         line_s <= line_m;
         done_m <= adc_done;
         done_s <= done_m;
         done_q <= done_s;
         data_m <= adc_data;
         data_s <= data_m;
         miso_m <= spi_miso;
         miso_s <= miso_m;
      end
   end

   assign adc_edge = done_s & ~done_q;
   assign cmd_wr   = reg_wr && (reg_addr == REG_COMMAND) && (state == S_IDLE);

   // ***************************************************
   // Selector range check
   // ***************************************************
   always_comb begin
      sel_bad = 1'b0;
      case (reg_wdata[2:0])
         // R3: four obstacle codes
         OP_OBS_DIG, OP_OBS_ANA:   sel_bad = (obs_sel > side_right_code);
         // R7: three axis codes
         OP_AXIS:                  sel_bad = (axis_sel > z_axis_code);
         // R11: two line codes
         OP_LINE_DIG, OP_LINE_ANA: sel_bad = (line_sel > line_right_code);
         default:                  sel_bad = 1'b0;
      endcase
   end

   // ***************************************************
   // Selector registers
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         obs_sel  <= 8'h00;
         axis_sel <= 8'h00;
         line_sel <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == REG_OBS_SEL) obs_sel <= reg_wdata;
         if (reg_addr == REG_AXIS_SEL) axis_sel <= reg_wdata;
         if (reg_addr == REG_LINE_SEL) line_sel <= reg_wdata;
      end
   end

   // ***************************************************
   // SPI requests
   // ***************************************************
   always_comb begin
      spi.start = 1'b0;
      spi.write = 1'b0;
      spi.addr  = ACC_STAT_REG;
      spi.wdata = 8'h00;
      case (state)
         S_A_MODE: begin
            spi.write = 1'b1;
            spi.addr  = ACC_MODE_REG;
            spi.wdata = ACC_MEASURE;
         end
         S_A_POLL: spi.addr = ACC_STAT_REG;
         S_A_READ: spi.addr = ACC_X_REG + cur_sel[5:0];
         S_A_BACK: begin
            spi.write = 1'b1;
            spi.addr  = ACC_MODE_REG;
            spi.wdata = ACC_TAP_MODE;
         end
         S_T_READ: spi.addr = ACC_TAP_REG;
         default:  spi.addr = ACC_STAT_REG;
      endcase
      case (state)
         S_A_MODE, S_A_POLL, S_A_READ, S_A_BACK, S_T_READ:
            spi.start = !issued && !spi.busy;
         default: spi.start = 1'b0;
      endcase
   end

   rss_spi u_spi (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .bus      (spi.engine),
      .spi_sclk (spi_sclk),
      .spi_mosi (spi_mosi),
      .spi_cs_n (spi_cs_n),
      .miso_s   (miso_s)
   );

   // ***************************************************
   // Sequencer
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state              <= S_IDLE;
         op                 <= 3'h0;
         cur_sel            <= 8'h00;
         tmr                <= 16'h0000;
         issued             <= 1'b0;
         ir_emit            <= 1'b0;
         line_emit          <= 1'b0;
         adc_start          <= 1'b0;
         adc_chan           <= 3'h0;
         read_ok_flag       <= 1'b0;
         bad_data_flag      <= 1'b0;
         obstacle_result    <= 8'h00;
         acceleration_value <= 8'h00;
         tap_event_flags    <= 8'h00;
         line_result        <= 8'h00;
      end else begin
         adc_start <= 1'b0;
         if (spi.start) issued <= 1'b1;
         if (spi.done) issued <= 1'b0;
         if (tmr != 16'h0000) tmr <= tmr - 16'h0001;
         case (state)
            S_IDLE: begin
               if (cmd_wr) begin
                  op            <= reg_wdata[2:0];
                  read_ok_flag  <= 1'b0;
                  bad_data_flag <= 1'b0;
                  // R14: bad code, no access
                  if (sel_bad) begin
                     bad_data_flag <= 1'b1;
                  end else begin
                     case (reg_wdata[2:0])
                        OP_OBS_DIG, OP_OBS_ANA: begin
                           cur_sel <= obs_sel;
                           state   <= S_PRE;
                        end
                        OP_AXIS: begin
                           cur_sel <= axis_sel;
                           state   <= S_A_MODE;
                        end
                        OP_TAP: state <= S_T_READ;
                        OP_LINE_DIG, OP_LINE_ANA: begin
                           cur_sel   <= line_sel;
                           line_emit <= 1'b1;
                           tmr       <= LINE_WAIT;
                           state     <= S_LFIRE;
                        end
                        default: state <= S_IDLE;
                     endcase
                  end
               end
            end
            // R1: no interference before pulse
            S_PRE: begin
               if (ir_s != 4'h0) begin
                  state <= S_IDLE;
               end else begin
                  ir_emit <= 1'b1;
                  tmr     <= IR_PULSE_CYC;
                  state   <= S_FIRE;
               end
            end
            S_FIRE: begin
               if (tmr == 16'h0000) begin
                  if (op == OP_OBS_ANA) begin
                     // R4: convert selected receiver
                     adc_start <= 1'b1;
                     adc_chan  <= cur_sel[2:0];
                     state     <= S_ADC;
                  end else begin
                     // R1: store level, emitter off
                     obstacle_result <= {7'h00, ir_s[cur_sel[1:0]]};
                     ir_emit         <= 1'b0;
                     tmr             <= IR_SETTLE_CYC;
                     state           <= S_OFF;
                  end
               end
            end
            S_ADC: begin
               if (adc_edge) begin
                  if (op == OP_OBS_ANA) begin
                     // R4: larger means nearer
                     obstacle_result <= data_s;
                     ir_emit         <= 1'b0;
                     tmr             <= IR_SETTLE_CYC;
                     state           <= S_OFF;
                  end else begin
                     // R10: larger means darker
                     line_result  <= 8'hFF - data_s;
                     line_emit    <= 1'b0;
                     read_ok_flag <= 1'b1;
                     state        <= S_IDLE;
                  end
               end
            end
            S_OFF: begin
               if (tmr == 16'h0000) state <= S_POST;
            end
            // R2: recheck after emitter off
            S_POST: begin
               read_ok_flag <= (ir_s == 4'h0);
               state        <= S_IDLE;
            end
            S_LFIRE: begin
               if (tmr == 16'h0000) begin
                  if (op == OP_LINE_ANA) begin
                     // R10: convert after the wait
                     adc_start <= 1'b1;
                     adc_chan  <= ADC_LINE_BASE + cur_sel[2:0];
                     state     <= S_ADC;
                  end else begin
                     // R9: dark reads as one
                     line_result  <= {7'h00, ~line_s[cur_sel[0]]};
                     line_emit    <= 1'b0;
                     read_ok_flag <= 1'b1;
                     state        <= S_IDLE;
                  end
               end
            end
            // R6: measure mode first
            S_A_MODE: begin
               if (spi.done) state <= S_A_POLL;
            end
            S_A_POLL: begin
               if (spi.done && spi.rdata[ACC_DRDY_BIT]) state <= S_A_READ;
            end
            S_A_READ: begin
               if (spi.done) begin
                  // R5: offset code, 0 is -2 G
                  acceleration_value <= {~spi.rdata[7], spi.rdata[6:0]};
                  state              <= S_A_BACK;
               end
            end
            // R6: back to tap mode
            S_A_BACK: begin
               if (spi.done) begin
                  read_ok_flag <= 1'b1;
                  state        <= S_IDLE;
               end
            end
            // R8: tap flags update
            S_T_READ: begin
               if (spi.done) begin
                  tap_event_flags <= 8'h00;
                  tap_event_flags[TAP_DOUBLE_BIT] <= spi.rdata[ACC_DOUBLE_BIT];
                  tap_event_flags[TAP_SINGLE_BIT] <= spi.rdata[ACC_SINGLE_BIT];
                  read_ok_flag    <= 1'b1;
                  state           <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ***************************************************
   // Lamps
   // ***************************************************
   // R13: shared blink timebase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt   <= 24'h000000;
         blink_phase <= 1'b0;
      end else if (blink_cnt >= BLINK_HALF - 24'h000001) begin
         blink_cnt   <= 24'h000000;
         blink_phase <= ~blink_phase;
      end else begin
         blink_cnt <= blink_cnt + 24'h000001;
      end
   end

   for (genvar i = 0; i < LAMPS; i++) begin : g_lamp
      // R12: on, off, blink per lamp
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            lamp_mode[i] <= LED_OFF;
         end else if (reg_wr && reg_addr == REG_LED_CMD && reg_wdata[1:0] == 2'(i)
                      && reg_wdata[3:2] != 2'h0) begin
            lamp_mode[i] <= reg_wdata[3:2];
         end
      end
      // R13: toggle until on or off
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            lamp[i] <= 1'b0;
         end else begin
            lamp[i] <= (lamp_mode[i] == LED_ON) ||
                       (lamp_mode[i] == LED_BLINK && blink_phase);
         end
      end
   end

   // ***************************************************
   // Register readback
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_OBS_SEL:   reg_rdata <= obs_sel;
            REG_AXIS_SEL:  reg_rdata <= axis_sel;
            REG_LINE_SEL:  reg_rdata <= line_sel;
            REG_STATUS: begin
               reg_rdata              <= 8'h00;
               reg_rdata[ST_OK_BIT]   <= read_ok_flag;
               reg_rdata[ST_BAD_BIT]  <= bad_data_flag;
               reg_rdata[ST_BUSY_BIT] <= (state != S_IDLE);
            end
            REG_OBS_RES:   reg_rdata <= obstacle_result;
            REG_ACC_RES:   reg_rdata <= acceleration_value;
            REG_TAP:       reg_rdata <= tap_event_flags;
            REG_LINE_RES:  reg_rdata <= line_result;
            REG_LED_STATE: reg_rdata <= {4'h0, lamp};
            default:       reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : rss_top

/* sim/rss_asserts.sv */
/* Port checker for rss_top; bound below, sees only top ports. */
`timescale 1ns/1ns
module rss_asserts import rss_pkg::*; #(parameter logic [15:0] LINE_WAIT = 16'd20) (
   input wire logic       core_clk, rst_n, reg_wr, ir_emit, line_emit, adc_start, spi_cs_n,
   input wire logic [3:0] reg_addr, ir_rx, lamp,
   input wire logic [7:0] reg_wdata);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] lc;
   wire led = reg_wr && reg_addr == REG_LED_CMD;
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n) lc <= 16'h0; else lc <= line_emit ? lc + 16'h1 : 16'h0;
   quiet_fire_a:
      assert property ($rose(ir_emit) |-> $past(ir_rx, 3) == 4'h0) else $error("pulse in noise");
   pulse_end_a:
      assert property ($rose(ir_emit) |-> ##[250:1000] !ir_emit) else $error("emitter stuck");
   line_wait_a:
      assert property ($fell(line_emit) |-> lc >= LINE_WAIT) else $error("line wait short");
   adc_lit_a:
      assert property (adc_start |-> ir_emit || line_emit) else $error("convert unlit");
   spi_frame_a:
      assert property ($fell(spi_cs_n) |-> ##[100:200] $rose(spi_cs_n)) else $error("bad frame");
   spi_dark_a:
      assert property (!spi_cs_n |-> !ir_emit && !line_emit) else $error("frame while lit");
   lamp_on_a:
      assert property (led && reg_wdata[3:2] == LED_ON |-> ##2 lamp[$past(reg_wdata[1:0], 2)])
         else $error("lamp not on");
   lamp_off_a:
      assert property (led && reg_wdata[3:2] == LED_OFF |-> ##2 !lamp[$past(reg_wdata[1:0], 2)])
         else $error("lamp not off");
   cover property ($rose(ir_emit));
   cover property ($fell(spi_cs_n));
   cover property ($fell(line_emit));
endmodule : rss_asserts
bind rss_top rss_asserts #(.LINE_WAIT(LINE_WAIT)) u_chk (.*);

/* sim/rss_partner.sv */
/* Far side: IR receivers, ADC, SPI accelerometer. Assumes rss_top pins. */
`timescale 1ns/1ns
module rss_partner import rss_pkg::*; (
   input wire logic       core_clk, ir_emit, adc_start, spi_sclk, spi_cs_n,
   input wire logic [3:0] noise, refl,
   input wire logic [7:0] acc,
   output logic [3:0]     ir_rx,
   output logic           adc_done, spi_miso,
   output logic [7:0]     adc_data);
   logic [2:0] w = 3'h0;
   logic [4:0] n = 5'h0;
   assign ir_rx    = noise | (ir_emit ? refl : 4'h0);
   assign adc_data = 8'h5A;
   assign adc_done = w == 3'h1;
   assign spi_miso = n[3] & acc[~n[2:0]];
   always @(posedge core_clk) if (adc_start) w <= 3'h6; else if (w > 3'h1) w <= w - 3'h1;
   always @(posedge spi_sclk or posedge spi_cs_n) n <= spi_cs_n ? 5'h0 : n + 5'h1;
endmodule : rss_partner

/* sim/rss_top_tb.sv */
/* Self-checking bench for rss_top. Assumes rss_partner and rss_asserts. */
`timescale 1ns/1ns
module rss_top_tb;
   import rss_pkg::*;
   logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ir_emit, line_emit, adc_start;
   logic adc_done, spi_sclk, spi_mosi, spi_cs_n, spi_miso;
   logic [3:0] reg_addr = 0, ir_rx, noise = 0, refl = 0, lamp;
   logic [7:0] reg_wdata = 0, reg_rdata, adc_data, acc = 8'h81, d;
   logic [2:0] adc_chan;
   logic [1:0] line_rx = 0;
   int bad_count = 0, samples_checked = 0, seed = 41992, cyc = 0, i, s;
   initial forever #20 core_clk = ~core_clk;
   rss_top #(.LINE_WAIT(16'd20), .BLINK_HALF(24'd8)) DUT (.*);
   rss_partner pm (.*);
   task automatic test_done;
      $display("checked %0d wrong %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (e !== g) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge core_clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
      @(posedge core_clk); reg_wr <= 0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge core_clk); reg_addr <= a; reg_rd <= 1;
      @(posedge core_clk); reg_rd <= 0;
      @(negedge core_clk); d = reg_rdata;
   endtask : rd
   task automatic run(logic [3:0] sr, int sel, logic [2:0] op, logic [3:0] ra);
      wr(sr, 8'(sel));
      wr(REG_COMMAND, {5'h0, op});
      for (int k = 0; k < 1000; k++) begin
         rd(REG_STATUS);
         if (d[ST_BUSY_BIT] === 1'b0) break;
      end
      rd(ra);
   endtask : run
   task automatic led(logic [1:0] c, int n);
      wr(REG_LED_CMD, {4'h0, c, 2'(n)});
      @(posedge core_clk);
      rd(REG_LED_STATE);
   endtask : led
   always @(posedge core_clk) if (++cyc > 90000) begin bad_count++; test_done(); end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1;
      rd(REG_STATUS); chk("status", 8'h00, d);
      rd(4'hF); chk("unmapped", 8'h00, d);
      for (s = 0; s < 8; s++) begin
         refl <= 4'($random(seed)); line_rx <= 2'($random(seed)); acc <= 8'($random(seed)) | 8'h01;
         run(REG_OBS_SEL, s % 4, OP_OBS_DIG, REG_OBS_RES); chk("obs", {7'h0, refl[s % 4]}, d);
         rd(REG_STATUS); chk("status", 8'h01, d);
         run(REG_OBS_SEL, s % 4, OP_OBS_ANA, REG_OBS_RES); chk("obs analog", 8'h5A, d);
         run(REG_LINE_SEL, s % 2, OP_LINE_DIG, REG_LINE_RES); chk("line", {7'h0, ~line_rx[s % 2]}, d);
         run(REG_LINE_SEL, s % 2, OP_LINE_ANA, REG_LINE_RES); chk("line analog", 8'hA5, d);
         run(REG_AXIS_SEL, s % 3, OP_AXIS, REG_ACC_RES); chk("axis", acc ^ 8'h80, d);
         run(REG_AXIS_SEL, 0, OP_TAP, REG_TAP); chk("tap", acc & 8'h03, d);
      end
      noise <= 4'h4;
      run(REG_OBS_SEL, 1, OP_OBS_DIG, REG_STATUS); chk("noisy", 8'h00, d);
      noise <= 4'h0;
      run(REG_OBS_SEL, 4, OP_OBS_DIG, REG_STATUS); chk("bad obs", 8'h02, d);
      run(REG_AXIS_SEL, 3, OP_AXIS, REG_STATUS); chk("bad axis", 8'h02, d);
      run(REG_LINE_SEL, 2, OP_LINE_DIG, REG_STATUS); chk("bad line", 8'h02, d);
      for (i = 0; i < 4; i++) begin
         led(LED_ON, i); chk("lamp on", 8'h1 << i, d);
         led(LED_BLINK, i); s = d; repeat (6) @(posedge core_clk);
         rd(REG_LED_STATE); chk("blink", 8'(s) ^ (8'h1 << i), d);
         led(LED_OFF, i); chk("lamp off", 8'h00, d);
      end
      test_done();
   end
endmodule : rss_top_tb
